// ==== rtl/flash_block_protection.sv ====
/*
  access gate for the on-chip flash: checks read, program and erase
  requests from fetch, data and debug against per-pair protection.
  assumes requesters share the clock and hold no request while ready is low.
*/
`timescale 1ns/100ps
module flash_block_protection
  import flash_prot_pkg::*;
(
  // clock and reset
  input  wire logic               clock,
  input  wire logic               reset,
  // protection setting
  input  wire logic               prot_wr,
  input  wire logic [PAIR_W-1:0]  prot_pair,
  input  wire logic [MODE_W-1:0]  prot_mode,
  // request
  input  wire logic               req_valid,
  input  wire logic [1:0]         req_op,
  input  wire logic [1:0]         req_src,
  input  wire logic [ADDR_W-1:0]  req_addr,
  input  wire logic [DATA_W-1:0]  req_wdata,
  output logic                    req_ready,
  // answer
  output logic                    rsp_valid,
  output logic [DATA_W-1:0]       rsp_data,
  output logic                    access_violation
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_ERASE = 2'b10
  } fsm_t;

  typedef struct packed {
    fsm_t                     state;
    logic [BLOCK_W-1:0]       erase_block;
    logic [BLOCK_WORD_W-1:0]  erase_cnt;
    logic [PAIRS*MODE_W-1:0]  prot;
    logic                     ready;
    logic                     rsp_valid;
    logic [DATA_W-1:0]        rsp_data;
    logic                     violation;
  } gate_t;

  localparam gate_t GATE_RESET = '{
    state:       ST_IDLE,
    erase_block: '0,
    erase_cnt:   '0,
    prot:        PROT_RESET,
    ready:       1'b1,
    rsp_valid:   1'b0,
    rsp_data:    DENIED_DATA,
    violation:   1'b0
  };

  gate_t                   st_reg;
  gate_t                   st_next;
  logic                    mem_we;
  logic [WORD_ADDR_W-1:0]  mem_waddr;
  logic [DATA_W-1:0]       mem_wdata;
  logic [DATA_W-1:0]       mem_rdata;
  logic [WORD_ADDR_W-1:0]  req_word;
  logic [PAIR_W-1:0]       req_pair;
  logic                    in_range;
  logic [MODE_W-1:0]       pair_mode;
  logic                    permitted;

  // bit position of a pair's mode field in the packed mode vector
  function automatic logic [PAIR_W:0] pair_slot(input logic [PAIR_W-1:0] pair);
    return {pair, 1'b0};
  endfunction : pair_slot

  assign req_word  = req_addr[ADDR_W-1:2];
  assign req_pair  = req_addr[ADDR_W-1:PAIR_SHIFT];
  assign in_range  = (req_addr < FLASH_LIMIT);
  assign pair_mode = in_range ? st_reg.prot[pair_slot(req_pair) +: MODE_W] : PROT_EXEC_ONLY;
  assign permitted = in_range && access_ok(req_op, req_src, pair_mode);

  flash_word_array u_array (
    .clock   (clock),
    .wr_en   (mem_we),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .rd_addr (req_word),
    .rd_data (mem_rdata)
  );

  always_comb begin
    st_next           = st_reg;
    st_next.rsp_valid = 1'b0;
    st_next.violation = 1'b0;
    mem_we            = 1'b0;
    mem_waddr         = req_word;
    mem_wdata         = mem_rdata & req_wdata;

    // per-pair mode, settable at any time
    if (prot_wr && (prot_pair < PAIR_W'(PAIRS))) begin
      st_next.prot[pair_slot(prot_pair) +: MODE_W] = prot_mode;
    end

    case (st_reg.state)
      ST_IDLE: begin
        if (req_valid) begin
          st_next.rsp_valid = 1'b1;
          st_next.rsp_data  = DENIED_DATA;
          if (!permitted) begin
            st_next.violation = 1'b1;
          end else begin
            case (req_op)
              OP_READ: begin
                st_next.rsp_data = mem_rdata;
              end
              OP_PROGRAM: begin
                // programming only clears bits
                mem_we = 1'b1;
              end
              OP_ERASE: begin
                st_next.rsp_valid   = 1'b0;
                st_next.state       = ST_ERASE;
                st_next.erase_block = req_addr[ADDR_W-1:BLOCK_SHIFT];
                st_next.erase_cnt   = '0;
                st_next.ready       = 1'b0;
              end
              default: begin
                st_next.violation = 1'b1;
              end
            endcase
          end
        end
      end
      ST_ERASE: begin
        // one word per cycle through the selected block
        mem_we    = 1'b1;
        mem_waddr = {st_reg.erase_block, st_reg.erase_cnt};
        mem_wdata = ERASED_WORD;
        if (st_reg.erase_cnt == LAST_WORD) begin
          st_next.state     = ST_IDLE;
          st_next.ready     = 1'b1;
          st_next.rsp_valid = 1'b1;
          st_next.rsp_data  = DENIED_DATA;
        end else begin
          st_next.erase_cnt = st_reg.erase_cnt + 1'b1;
        end
      end
      default: begin
        st_next.state = ST_IDLE;
        st_next.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_reg <= GATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign req_ready        = st_reg.ready;
  assign rsp_valid        = st_reg.rsp_valid;
  assign rsp_data         = st_reg.rsp_data;
  assign access_violation = st_reg.violation;

endmodule : flash_block_protection

// ==== rtl/flash_prot_pkg.sv ====
/*
  constants, types and access-check helpers for the flash protection gate.
  assumes one clock domain; requesters sit on the same clock.
*/
package flash_prot_pkg;

  localparam int FLASH_BYTES  = 98304;
  localparam int WORD_BYTES   = 4;
  localparam int FLASH_WORDS  = FLASH_BYTES / WORD_BYTES;
  localparam int ADDR_W       = 17;
  localparam int WORD_ADDR_W  = 15;
  localparam int DATA_W       = 32;
  localparam int BLOCK_SHIFT  = 10;
  localparam int PAIR_SHIFT   = 11;
  localparam int BLOCK_W      = ADDR_W - BLOCK_SHIFT;
  localparam int BLOCK_WORD_W = BLOCK_SHIFT - 2;
  localparam int PAIRS        = 48;
  localparam int PAIR_W       = 6;
  localparam int MODE_W       = 2;

  localparam logic [ADDR_W-1:0]       FLASH_LIMIT  = 17'h18000;
  localparam logic [BLOCK_WORD_W-1:0] LAST_WORD    = 8'hff;
  localparam logic [DATA_W-1:0]       ERASED_WORD  = 32'hffffffff;
  localparam logic [DATA_W-1:0]       DENIED_DATA  = 32'h00000000;

  typedef enum logic [1:0] {
    OP_READ    = 2'h0,
    OP_PROGRAM = 2'h1,
    OP_ERASE   = 2'h2
  } op_t;

  typedef enum logic [1:0] {
    SRC_FETCH = 2'h0,
    SRC_DATA  = 2'h1,
    SRC_DEBUG = 2'h2
  } src_t;

  // code 3 behaves as execute-only
  typedef enum logic [1:0] {
    PROT_NONE      = 2'h0,
    PROT_READ_ONLY = 2'h1,
    PROT_EXEC_ONLY = 2'h2
  } prot_t;

  localparam logic [PAIRS*MODE_W-1:0] PROT_RESET = '0;

  function automatic logic access_ok(input logic [1:0] op, input logic [1:0] src,
                                     input logic [1:0] mode);
    logic ok;
    ok = 1'b0;
    if (op == OP_READ) begin
      ok = (mode == PROT_NONE) || (mode == PROT_READ_ONLY) || (src == SRC_FETCH);
    end else if (op == OP_PROGRAM || op == OP_ERASE) begin
      ok = (mode == PROT_NONE);
    end
    return ok;
  endfunction : access_ok

endpackage : flash_prot_pkg

// ==== rtl/flash_word_array.sv ====
/*
  flash storage array, one word per entry, combinational read.
  assumes the gate in front of it decides every write.
*/
`timescale 1ns/100ps
module flash_word_array
  import flash_prot_pkg::*;
(
  // clock
  input  wire logic                   clock,
  // write port
  input  wire logic                   wr_en,
  input  wire logic [WORD_ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0]      wr_data,
  // read port
  input  wire logic [WORD_ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0]      rd_data
);

  logic [DATA_W-1:0] mem [FLASH_WORDS];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];

endmodule : flash_word_array

// ==== verification/flash_gate_checker.sv ====
/* port assertions for the flash gate.
   assumes binding onto flash_block_protection. */
`timescale 1ns/100ps
module flash_gate_checker
  import flash_prot_pkg::*;
(
  // watched ports
  input wire logic              clock,
  input wire logic              reset,
  input wire logic              req_valid,
  input wire logic [1:0]        req_op,
  input wire logic [1:0]        req_src,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire logic [DATA_W-1:0] rsp_data,
  input wire logic              access_violation
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic tk;
  assign tk = req_valid && req_ready;
  a_quick_answer: assert property (tk && req_op != OP_ERASE |=> rsp_valid)
    else $error("late answer");
  a_sweep_len: assert property ($fell(req_ready) |-> ##255 !req_ready ##1 req_ready)
    else $error("sweep length");
  a_busy_quiet: assert property (!req_ready |-> !rsp_valid)
    else $error("answer while busy");
  a_erase_done: assert property ($rose(req_ready) |-> rsp_valid && !access_violation)
    else $error("erase answer");
  a_refuse_data: assert property (access_violation |-> rsp_valid && rsp_data == DENIED_DATA)
    else $error("refusal shape");
  a_range_refused: assert property (tk && req_addr >= FLASH_LIMIT |=> access_violation)
    else $error("range");
  a_bad_op: assert property (tk && req_op == 2'h3 |=> access_violation)
    else $error("bad op");
  a_fetch_served: assert property (tk && req_op == OP_READ && req_src == SRC_FETCH
    && req_addr < FLASH_LIMIT |=> !access_violation)
    else $error("fetch refused");
  cover property (tk && req_op == OP_ERASE);
  cover property (access_violation);
  cover property ($rose(req_ready));
endmodule : flash_gate_checker
bind flash_block_protection flash_gate_checker u_chk (.clock(clock), .reset(reset),
  .req_valid(req_valid), .req_op(req_op), .req_src(req_src), .req_addr(req_addr),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .access_violation(access_violation));

// ==== verification/flash_requester.sv ====
/* requester model: fetch, data and debug masters on one port.
   assumes one answer per taken request. */
`timescale 1ns/100ps
module flash_requester
  import flash_prot_pkg::*;
(
  // clock, ready and answer
  input  wire logic              clock,
  input  wire logic              req_ready,
  input  wire logic              rsp_valid,
  input  wire logic [DATA_W-1:0] rsp_data,
  input  wire logic              access_violation,
  // request
  output logic                   req_valid,
  output logic [1:0]             req_op,
  output logic [1:0]             req_src,
  output logic [ADDR_W-1:0]      req_addr,
  output logic [DATA_W-1:0]      req_wdata
);
  initial begin
    req_valid = 1'b0;
    req_op = 2'h0;
    req_src = 2'h0;
    req_addr = 17'h0;
    req_wdata = 32'h0;
  end
  task automatic xfer(input logic [1:0] op, input logic [1:0] src,
    input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
    output logic [DATA_W-1:0] d, output logic v);
    int n;
    @(posedge clock);
    req_valid <= 1'b1;
    req_op <= op;
    req_src <= src;
    req_addr <= a;
    req_wdata <= wd;
    do @(posedge clock); while (!req_ready);
    req_valid <= 1'b0;
    // released lines show garbage
    req_addr <= ~a;
    req_wdata <= ~wd;
    n = 0;
    #1;
    while (!rsp_valid && n < 300) begin
      @(posedge clock);
      #1;
      n++;
    end
    // a missing answer comes back unknown so the compare counts it
    d = rsp_valid ? rsp_data : 'x;
    v = rsp_valid ? access_violation : 1'bx;
  endtask : xfer
endmodule : flash_requester

// ==== verification/flash_block_protection_tb_top.sv ====
/* bench: request table, then mode 3 and mid-run reset.
   assumes the requester model and the bound checker. */
`timescale 1ns/100ps
module flash_block_protection_tb_top;
  import flash_prot_pkg::*;
  logic clock = 1'b0, reset = 1'b1, prot_wr = 1'b0, req_valid, req_ready, rsp_valid, v;
  logic access_violation;
  logic [1:0] req_op, req_src, prot_mode = 2'h0;
  logic [5:0] prot_pair = 6'h0;
  logic [16:0] req_addr;
  logic [31:0] req_wdata, rsp_data, d;
  int mismatches = 0, cmp_count = 0;
  logic [85:0] rows [16] = '{{2'h2,2'h1,17'h0,32'h0,32'h0,1'h0},
    {2'h2,2'h1,17'h800,32'h0,32'h0,1'h0}, {2'h2,2'h1,17'h1000,32'h0,32'h0,1'h0},
    {2'h0,2'h2,17'h3fc,32'h0,32'hffffffff,1'h0}, {2'h1,2'h1,17'h800,32'ha5a5a5a5,32'h0,1'h0},
    {2'h1,2'h1,17'h1000,32'h5a5a5a5a,32'h0,1'h0}, {2'h2,2'h1,17'h800,32'h0,32'h0,1'h1},
    {2'h1,2'h1,17'h800,32'h0,32'h0,1'h1}, {2'h0,2'h2,17'h800,32'h0,32'ha5a5a5a5,1'h0},
    {2'h2,2'h0,17'h1000,32'h0,32'h0,1'h1}, {2'h1,2'h0,17'h1000,32'h0,32'h0,1'h1},
    {2'h0,2'h1,17'h1000,32'h0,32'h0,1'h1}, {2'h0,2'h2,17'h1000,32'h0,32'h0,1'h1},
    {2'h0,2'h0,17'h1000,32'h0,32'h5a5a5a5a,1'h0}, {2'h0,2'h0,17'h18000,32'h0,32'h0,1'h1},
    {2'h3,2'h0,17'h0,32'h0,32'h0,1'h1}};
  always #2.5 clock = ~clock;
  flash_block_protection dut (.clock(clock), .reset(reset), .prot_wr(prot_wr),
    .prot_pair(prot_pair), .prot_mode(prot_mode), .req_valid(req_valid), .req_op(req_op),
    .req_src(req_src), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .access_violation(access_violation));
  flash_requester u_req (.clock(clock), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .access_violation(access_violation), .req_valid(req_valid),
    .req_op(req_op), .req_src(req_src), .req_addr(req_addr), .req_wdata(req_wdata));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic setp(input logic [5:0] p, input logic [1:0] m);
    @(posedge clock);
    prot_wr <= 1'b1;
    prot_pair <= p;
    prot_mode <= m;
    @(posedge clock);
    prot_wr <= 1'b0;
  endtask : setp
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (i == 6) begin
        setp(6'h1, 2'h1);
        setp(6'h2, 2'h2);
      end
      u_req.xfer(rows[i][85:84], rows[i][83:82], rows[i][81:65], rows[i][64:33], d, v);
      chk(d, rows[i][32:1]);
      chk({31'h0, v}, {31'h0, rows[i][0]});
      $display("row %0d done", i);
    end
    setp(6'h3, 2'h3);
    u_req.xfer(2'h0, 2'h1, 17'h1800, 32'h0, d, v);
    chk({31'h0, v}, 32'h1);
    u_req.xfer(2'h0, 2'h3, 17'h1800, 32'h0, d, v);
    chk({31'h0, v}, 32'h1);
    u_req.xfer(2'h0, 2'h0, 17'h1800, 32'h0, d, v);
    chk({31'h0, v}, 32'h0);
    $display("mode 3 done");
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    chk({30'h0, req_ready, rsp_valid}, 32'h2);
    u_req.xfer(2'h0, 2'h1, 17'h1000, 32'h0, d, v);
    chk(d, 32'h5a5a5a5a);
    chk({31'h0, v}, 32'h0);
    $display("reset done");
    print_verdict();
  end
endmodule : flash_block_protection_tb_top
